// ### include/dpc_defines.vh
/*
 * Constants for the single-port host controller of a dual-port static RAM:
 * clock period, timing figures in ns, derived cycle counts, widths.
 * Assumes the includer runs at the rate in DPC_CLK_PERIOD_NS.
 */
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

// ----------------------------------------------------------------
// Clock and widths
// ----------------------------------------------------------------
`define DPC_CLK_PERIOD_NS 100
`define DPC_ADDR_W 14
`define DPC_DATA_W 16
`define DPC_CNT_W 4

// ----------------------------------------------------------------
// Times in ns
// ----------------------------------------------------------------
`define DPC_WRITE_PULSE_NS 25
`define DPC_FLAG_WRITE_TO_READ_NS 5
`define DPC_WRITE_HOLD_NS 25
`define DPC_READ_ACCESS_NS 55
`define DPC_FLAG_RELEASE_TO_VALID_DATA_NS 40
`define DPC_OUTPUT_OFF_NS 25

// ----------------------------------------------------------------
// Cycle counts, least times rounded up
// ----------------------------------------------------------------
`define DPC_CEIL_CYC(ns) (((ns) + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS)
`define DPC_WRITE_PULSE_CYC `DPC_CEIL_CYC(`DPC_WRITE_PULSE_NS)
`define DPC_FLAG_WRITE_TO_READ_CYC `DPC_CEIL_CYC(`DPC_FLAG_WRITE_TO_READ_NS)
`define DPC_WRITE_HOLD_CYC `DPC_CEIL_CYC(`DPC_WRITE_HOLD_NS)
`define DPC_READ_ACCESS_CYC `DPC_CEIL_CYC(`DPC_READ_ACCESS_NS)
`define DPC_RELEASE_TO_DATA_CYC `DPC_CEIL_CYC(`DPC_FLAG_RELEASE_TO_VALID_DATA_NS)
`define DPC_OUTPUT_OFF_CYC `DPC_CEIL_CYC(`DPC_OUTPUT_OFF_NS)

`endif

// ### verification/dpc_port_assertions.sv
/* Checker on the host pins of dpc_port_ctrl.
   Assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"
module dpc_port_assertions
(
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic [`DPC_ADDR_W-1:0] ram_addr,
    input wire logic                   ram_chip_enable_n,
    input wire logic                   ram_read_write_n,
    input wire logic                   ram_output_enable_n,
    input wire logic                   flag_select_n,
    input wire logic [`DPC_DATA_W-1:0] ram_data_out,
    input wire logic                   ram_data_oe,
    input wire logic                   contention_flag_n
);
// ----------------------------------------
// Strobe and bus discipline
// ----------------------------------------
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!resetn);
a_one_target: assert property (ram_chip_enable_n || flag_select_n)
    else $error("array and flag both selected");
a_target_held: assert property (!ram_read_write_n && !$past(ram_read_write_n)
    |-> $stable(ram_chip_enable_n) && $stable(flag_select_n)) else $error("select moved in write");
a_addr_quiet: assert property ($changed(ram_addr)
    |-> ram_read_write_n || (ram_chip_enable_n && flag_select_n)) else $error("address moved in strobe");
a_no_fight: assert property ((!ram_output_enable_n || !$past(ram_output_enable_n))
    |-> !ram_data_oe) else $error("host drove data during read");
a_write_oe_off: assert property (!ram_read_write_n |-> ram_output_enable_n && ram_data_oe)
    else $error("write with outputs enabled");
a_pulse_min: assert property ($fell(ram_read_write_n) |=> !ram_read_write_n)
    else $error("write pulse too short");
a_data_steady: assert property (!ram_read_write_n && !$past(ram_read_write_n)
    |-> $stable(ram_data_out)) else $error("data moved in write");
a_flag_gap: assert property ($rose(flag_select_n) && !$past(ram_read_write_n)
    |=> flag_select_n) else $error("flag read too soon");
a_wait_busy: assert property (!ram_read_write_n && !contention_flag_n |=> !ram_read_write_n)
    else $error("write ended under contention");
a_hold_after: assert property (!$past(ram_read_write_n) && !ram_read_write_n && $rose(contention_flag_n)
    |=> !ram_read_write_n [*2]) else $error("write hold too short");
a_read_wait: assert property (!ram_output_enable_n && !contention_flag_n |=> !ram_output_enable_n)
    else $error("read ended under contention");
endmodule // dpc_port_assertions
bind dpc_port_ctrl dpc_port_assertions u_chk
(
    .sys_clk, .resetn, .ram_addr, .ram_chip_enable_n, .ram_read_write_n,
    .ram_output_enable_n, .flag_select_n, .ram_data_out, .ram_data_oe, .contention_flag_n
);
`default_nettype wire

// ### verification/dpc_ram_model.sv
/* Behavioural model of one port of the dual-port RAM, slave mode.
   Assumes the bench resolves the data bus and drives the peer side. */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"
module dpc_ram_model
(
    input  wire logic [`DPC_ADDR_W-1:0] ram_addr,
    input  wire logic                   ram_chip_enable_n,
    input  wire logic                   ram_read_write_n,
    input  wire logic                   ram_output_enable_n,
    input  wire logic                   flag_select_n,
    input  wire logic                   upper_byte_select_n,
    input  wire logic                   lower_byte_select_n,
    input  wire logic [`DPC_DATA_W-1:0] ram_data_out,
    input  wire logic                   ram_data_oe,
    input  wire logic                   contention_flag_n,
    input  wire logic                   peer_hold,
    output wire logic [`DPC_DATA_W-1:0] dev_dout
);
// ----------------------------------------
// Storage and flags
// ----------------------------------------
logic [15:0] mem_ff [0:16383]; // Array cells
logic [7:0]  own_ff;           // Flags held by this port
logic [7:0]  pend_ff;          // Requests waiting on the peer
logic [15:0] last_ff;          // Last driven read value
wire logic wr_on = !ram_read_write_n && contention_flag_n && ram_data_oe;
wire logic rd_on = ram_read_write_n && !ram_output_enable_n && !(ram_chip_enable_n && flag_select_n);
wire logic [2:0] fi = ram_addr[2:0];
// One array shared with the peer port, written data read back
wire logic [15:0] rd_val = flag_select_n ? mem_ff[ram_addr] : {16{~own_ff[fi]}};
initial
begin
    for (int i = 0; i < 16384; i++) mem_ff[i] = 16'h0000;
    {own_ff, pend_ff, last_ff} = 32'h0000_0000;
end
// Level write while enable and strobe are low
always @*
    if (wr_on && !ram_chip_enable_n && flag_select_n)
    begin
        if (!lower_byte_select_n) mem_ff[ram_addr][7:0] = ram_data_out[7:0];
        if (!upper_byte_select_n) mem_ff[ram_addr][15:8] = ram_data_out[15:8];
    end
// Zero requests, one releases; only one side ever holds the token
always @*
    if (wr_on && ram_chip_enable_n && !flag_select_n)
    begin
        if (ram_data_out[0]) {own_ff[fi], pend_ff[fi]} = 2'h0;
        else if (!peer_hold) own_ff[fi] = 1'b1;
        else pend_ff[fi] = 1'b1;
    end
// Peer release hands over pending tokens
always @(negedge peer_hold) {own_ff, pend_ff} = {own_ff | pend_ff, 8'h00};
always @* if (rd_on) last_ff = rd_val;
// Released bus shows the inverse, never a stale copy
assign dev_dout = rd_on ? rd_val : ~last_ff;
endmodule // dpc_ram_model
`default_nettype wire

// ### verification/testbench.sv
/* Self-checking bench for dpc_port_ctrl against the RAM model.
   Assumes a 10 MHz clock; inputs change on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"
module testbench;
logic sys_clk, resetn, clk_en, req_valid, req_write, req_flag, contention_flag_n, peer_hold;
logic [`DPC_ADDR_W-1:0] req_addr, a;
logic [`DPC_DATA_W-1:0] req_wdata, d, e, rd;
logic [1:0] req_byte_en, be;
logic w, f, ct;
int num_errors = 0, n_checks = 0, i, k, n;
wire logic req_ready, rsp_valid, rsp_contended, ram_chip_enable_n, ram_read_write_n, ram_data_oe;
wire logic ram_output_enable_n, flag_select_n, upper_byte_select_n, lower_byte_select_n;
wire logic [`DPC_ADDR_W-1:0] ram_addr;
wire logic [`DPC_DATA_W-1:0] rsp_rdata, ram_data_out, ram_data_in, dev_dout;
// Rows: write, flag, address, data, lanes, expected read
logic [49:0] rows [0:10] = '{
    {1'b1, 1'b0, 14'h0000, 16'ha5a5, 2'h3, 16'h0000}, {1'b0, 1'b0, 14'h0000, 16'h0000, 2'h3, 16'ha5a5},
    {1'b1, 1'b0, 14'h3fff, 16'h1234, 2'h1, 16'h0000}, {1'b0, 1'b0, 14'h3fff, 16'h0000, 2'h3, 16'h0034},
    {1'b1, 1'b0, 14'h3fff, 16'h5600, 2'h2, 16'h0000}, {1'b0, 1'b0, 14'h3fff, 16'h0000, 2'h3, 16'h5634},
    {1'b1, 1'b1, 14'h0002, 16'h0000, 2'h3, 16'h0000}, {1'b0, 1'b1, 14'h0002, 16'h0000, 2'h3, 16'h0000},
    {1'b1, 1'b1, 14'h0002, 16'hffff, 2'h3, 16'h0000}, {1'b0, 1'b1, 14'h0002, 16'h0000, 2'h3, 16'hffff},
    {1'b0, 1'b0, 14'h0002, 16'h0000, 2'h3, 16'h0000}};
// ----------------------------------------
// Design, model and shared data bus
// ----------------------------------------
dpc_port_ctrl uut (.sys_clk, .resetn, .clk_en, .req_valid, .req_ready, .req_write, .req_flag, .req_addr,
    .req_wdata, .req_byte_en, .rsp_valid, .rsp_rdata, .rsp_contended, .ram_addr, .ram_chip_enable_n,
    .ram_read_write_n, .ram_output_enable_n, .flag_select_n, .upper_byte_select_n, .lower_byte_select_n,
    .ram_data_out, .ram_data_oe, .ram_data_in, .contention_flag_n);
dpc_ram_model dev (.ram_addr, .ram_chip_enable_n, .ram_read_write_n, .ram_output_enable_n, .flag_select_n,
    .upper_byte_select_n, .lower_byte_select_n, .ram_data_out, .ram_data_oe, .contention_flag_n,
    .peer_hold, .dev_dout);
assign ram_data_in = ram_data_oe ? ram_data_out : dev_dout;
initial
begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
end
// ----------------------------------------
// Tasks
// ----------------------------------------
task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic end_sim;
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
// Idle pin levels: strobes high, no drive, ready
task automatic idle_chk;
    check("idle pins", {ram_chip_enable_n, ram_read_write_n, ram_output_enable_n, flag_select_n,
        upper_byte_select_n, lower_byte_select_n, ram_data_oe, rsp_valid, req_ready}, 9'h1f9);
endtask
task automatic xfer(input logic tw, tf, input logic [13:0] ta, input logic [15:0] td, input logic [1:0] tb);
    int m;
    @(negedge sys_clk);
    for (m = 0; m < 60 && req_ready !== 1'b1; m++) @(negedge sys_clk);
    {req_valid, req_write, req_flag, req_addr, req_wdata, req_byte_en} = {1'b1, tw, tf, ta, td, tb};
    @(negedge sys_clk);
    req_valid = 1'b0;
    check("busy ready", req_ready, 1'b0);
    for (m = 0; m < 60 && rsp_valid !== 1'b1; m++) @(negedge sys_clk);
    check("done", rsp_valid, 1'b1);
    {rd, ct} = {rsp_rdata, rsp_contended};
endtask
// Whole run needs well under 2000 cycles
initial
begin
    #400000;
    num_errors++;
    end_sim();
end
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial
begin
    {resetn, clk_en, req_valid, req_write, req_flag, contention_flag_n, peer_hold} = 7'h26;
    {req_addr, req_wdata, req_byte_en} = 32'h0000_0000;
    repeat (16) @(negedge sys_clk);
    idle_chk();
    resetn = 1'b1;
    @(negedge sys_clk);
    idle_chk();
    for (i = 0; i < 11; i++)
    begin
        {w, f, a, d, be, e} = rows[i];
        xfer(w, f, a, d, be);
        if (!w) check("read data", rd, e);
        check("no contention", ct, 1'b0);
    end
    // Peer holds the flag: request waits, then is granted
    peer_hold = 1'b1;
    xfer(1'b1, 1'b1, 14'h0003, 16'h0000, 2'h3);
    xfer(1'b0, 1'b1, 14'h0003, 16'h0000, 2'h3);
    check("pending flag", rd, 16'hffff);
    peer_hold = 1'b0;
    xfer(1'b0, 1'b1, 14'h0003, 16'h0000, 2'h3);
    check("granted flag", rd, 16'h0000);
    // Contention raised before the strobe, write then read
    for (k = 0; k < 2; k++)
    begin
        fork
            xfer(k == 0, 1'b0, 14'h0005, 16'h0f0f, 2'h3);
            begin
                for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge sys_clk);
                for (n = 0; n < 20 && req_ready !== 1'b0; n++) @(negedge sys_clk);
                // Arbiter input low in setup, ahead of the strobe
                contention_flag_n = 1'b0;
                repeat (4) @(negedge sys_clk);
                check("inhibited", dev.mem_ff[5], k ? 16'h0f0f : 16'h0000);
                contention_flag_n = 1'b1;
            end
        join
        check("contended", ct, 1'b1);
        if (k) check("late data", rd, 16'h0f0f);
    end
    // Freeze mid-write, then read back
    fork
        xfer(1'b1, 1'b0, 14'h0007, 16'h7777, 2'h3);
        begin
            for (n = 0; n < 20 && ram_read_write_n !== 1'b0; n++) @(negedge sys_clk);
            clk_en = 1'b0;
            repeat (5) @(negedge sys_clk);
            check("frozen", rsp_valid, 1'b0);
            check("strobe held", ram_read_write_n, 1'b0);
            clk_en = 1'b1;
        end
    join
    xfer(1'b0, 1'b0, 14'h0007, 16'h0000, 2'h3);
    check("after freeze", rd, 16'h7777);
    // Reset in mid-strobe of a write that never completes
    @(negedge sys_clk);
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge sys_clk);
    {req_valid, req_write, req_flag, req_addr, req_wdata} = {3'h6, 14'h0009, 16'h9999};
    @(negedge sys_clk);
    req_valid = 1'b0;
    for (n = 0; n < 20 && ram_chip_enable_n !== 1'b0; n++) @(negedge sys_clk);
    resetn = 1'b0;
    #1 idle_chk();
    @(negedge sys_clk);
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk) idle_chk();
    xfer(1'b0, 1'b0, 14'h0000, 16'h0000, 2'h3);
    check("after reset", rd, 16'ha5a5);
    end_sim();
end
endmodule // testbench
`default_nettype wire

// ### verilog/dpc_delay_timer.v
/*
 * Down-counting delay timer used to stretch pin phases.
 * Assumes load and load_val come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"

module dpc_delay_timer
(
    input  wire                    sys_clk,   // System clock
    input  wire                    resetn,    // Async reset, active low
    input  wire                    clk_en,    // Freezes count when low
    input  wire                    load,      // Start a new delay
    input  wire [`DPC_CNT_W-1:0]   load_val,  // Cycles to wait
    output wire                    busy       // Delay still running
);

    reg [`DPC_CNT_W-1:0] count_ff;  // Remaining cycles

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Load wins over decrement
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            count_ff <= 4'h0;
        else if (clk_en)
        begin
            if (load)
                count_ff <= load_val;
            else if (count_ff != 4'h0)
                count_ff <= count_ff - 4'h1;
        end
    end

    assign busy = (count_ff != 4'h0);

endmodule // dpc_delay_timer

`default_nettype wire

// ### verilog/dpc_port_ctrl.v
/*
 * Host controller for one port of an asynchronous dual-port static RAM:
 * array and semaphore flag reads and writes, with contention waits.
 * Assumes the RAM pins are sampled synchronously to sys_clk and that the
 * pin wiring resolves ram_data_out and ram_data_oe into a shared bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defines.vh"

module dpc_port_ctrl
(
    input  wire                    sys_clk,              // System clock
    input  wire                    resetn,               // Async reset, active low
    input  wire                    clk_en,               // Freezes all state when low
    input  wire                    req_valid,            // Request offered
    output wire                    req_ready,            // Request taken this edge
    input  wire                    req_write,            // 1 write, 0 read
    input  wire                    req_flag,             // 1 semaphore flag, 0 array
    input  wire [`DPC_ADDR_W-1:0]  req_addr,             // Word or flag address
    input  wire [`DPC_DATA_W-1:0]  req_wdata,            // Write data
    input  wire [1:0]              req_byte_en,          // Bit1 upper, bit0 lower
    output wire                    rsp_valid,            // One-cycle completion
    output wire [`DPC_DATA_W-1:0]  rsp_rdata,            // Read data
    output wire                    rsp_contended,        // Contention seen
    output wire [`DPC_ADDR_W-1:0]  ram_addr,             // Address pins
    output wire                    ram_chip_enable_n,    // Array select
    output wire                    ram_read_write_n,     // Write strobe
    output wire                    ram_output_enable_n,  // Output enable
    output wire                    flag_select_n,        // Semaphore select
    output wire                    upper_byte_select_n,  // Upper byte select
    output wire                    lower_byte_select_n,  // Lower byte select
    output wire [`DPC_DATA_W-1:0]  ram_data_out,         // Data to the RAM
    output wire                    ram_data_oe,          // High while driving data
    input  wire [`DPC_DATA_W-1:0]  ram_data_in,          // Data from the RAM
    input  wire                    contention_flag_n     // Port contention flag
);

    // ------------------------------------------------------------
    // States, one-hot
    // ------------------------------------------------------------
    localparam [5:0] ST_IDLE    = 6'b00_0001;  // Waiting for a request
    localparam [5:0] ST_SETUP   = 6'b00_0010;  // Address out, strobes high
    localparam [5:0] ST_STROBE  = 6'b00_0100;  // Strobes active
    localparam [5:0] ST_HOLD    = 6'b00_1000;  // Post-release hold
    localparam [5:0] ST_RELEASE = 6'b01_0000;  // Strobes high, address held
    localparam [5:0] ST_GAP     = 6'b10_0000;  // Turnaround before next

    localparam integer PULSE_I  = `DPC_WRITE_PULSE_CYC;         // Write pulse cycles
    localparam integer ACCESS_I = `DPC_READ_ACCESS_CYC;         // Read access cycles
    localparam integer WHOLD_I  = `DPC_WRITE_HOLD_CYC;          // Hold after release
    localparam integer RDATA_I  = `DPC_RELEASE_TO_DATA_CYC;     // Data after release
    localparam integer FGAP_I   = `DPC_FLAG_WRITE_TO_READ_CYC;  // Flag write to read
    localparam integer OFF_I    = `DPC_OUTPUT_OFF_CYC;          // Output turn-off

    // Counts cut to the timer width on purpose
    localparam [`DPC_CNT_W-1:0] PULSE_CYC  = PULSE_I[`DPC_CNT_W-1:0];
    localparam [`DPC_CNT_W-1:0] ACCESS_CYC = ACCESS_I[`DPC_CNT_W-1:0];
    localparam [`DPC_CNT_W-1:0] WHOLD_CYC  = WHOLD_I[`DPC_CNT_W-1:0];
    localparam [`DPC_CNT_W-1:0] RDATA_CYC  = RDATA_I[`DPC_CNT_W-1:0];
    localparam [`DPC_CNT_W-1:0] FGAP_CYC   = FGAP_I[`DPC_CNT_W-1:0];
    localparam [`DPC_CNT_W-1:0] OFF_CYC    = OFF_I[`DPC_CNT_W-1:0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [5:0]              state_ff;       // Current state
    reg [5:0]              nxt_state;      // Next state
    reg                    write_ff;       // Latched direction
    reg                    flag_ff;        // Latched target
    reg [`DPC_ADDR_W-1:0]  addr_ff;        // Latched address
    reg [`DPC_DATA_W-1:0]  wdata_ff;       // Latched write data
    reg [1:0]              byte_en_ff;     // Latched byte enables
    reg                    seen_ff;        // Contention seen in strobe
    reg                    nxt_seen;       // Next contention flag
    reg [`DPC_DATA_W-1:0]  rdata_ff;       // Captured read data
    reg                    rsp_valid_ff;   // Completion pulse
    reg                    rsp_cont_ff;    // Completion contention
    reg                    ce_n_ff;        // Chip enable pin
    reg                    rw_n_ff;        // Read/write pin
    reg                    oe_n_ff;        // Output enable pin
    reg                    sem_n_ff;       // Flag select pin
    reg                    ub_n_ff;        // Upper byte pin
    reg                    lb_n_ff;        // Lower byte pin
    reg                    doe_ff;         // Data drive enable
    reg                    tmr_load;       // Timer start
    reg [`DPC_CNT_W-1:0]   tmr_val;        // Timer length
    wire                   tmr_busy;       // Timer running
    wire                   take;           // Request accepted
    wire                   active;         // Strobe phase next cycle
    wire                   drive;          // Data driven next cycle

    assign take      = req_valid && state_ff[0];
    assign req_ready = state_ff[0];

    // ------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------
    dpc_delay_timer u_timer
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .load     (tmr_load),
        .load_val (tmr_val),
        .busy     (tmr_busy)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Strobe ends only once its width is met and contention is gone
    always @*
    begin
        nxt_state = state_ff;
        nxt_seen  = seen_ff;
        tmr_load  = 1'b0;
        tmr_val   = 4'h0;
        case (state_ff)
            ST_IDLE:
            begin
                if (take)
                    nxt_state = ST_SETUP;
            end
            ST_SETUP:
            begin
                // Pulse stretched to minimum width
                nxt_state = ST_STROBE;
                nxt_seen  = 1'b0;
                tmr_load  = 1'b1;
                tmr_val   = write_ff ? PULSE_CYC : ACCESS_CYC;
            end
            ST_STROBE:
            begin
                // Low flag blocks the write, keep strobing
                if (!contention_flag_n)
                    nxt_seen = 1'b1;
                if (!tmr_busy && contention_flag_n)
                begin
                    if (seen_ff)
                    begin
                        // Hold after release; and
                        nxt_state = ST_HOLD;
                        tmr_load  = 1'b1;
                        tmr_val   = write_ff ? WHOLD_CYC : RDATA_CYC;
                    end
                    else
                        nxt_state = ST_RELEASE;
                end
            end
            ST_HOLD:
            begin
                if (!tmr_busy)
                    nxt_state = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                // Flag write to read spacing, output turn-off; and
                nxt_state = ST_GAP;
                tmr_load  = 1'b1;
                tmr_val   = (write_ff && flag_ff) ? FGAP_CYC : OFF_CYC;
            end
            ST_GAP:
            begin
                if (!tmr_busy)
                    nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    assign active = nxt_state[2] || nxt_state[3];
    assign drive  = write_ff && (active || nxt_state[4]);

    // ------------------------------------------------------------
    // State and request latches
    // ------------------------------------------------------------
    // Request held stable from acceptance to the end of the gap
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff   <= ST_IDLE;
            seen_ff    <= 1'b0;
            write_ff   <= 1'b0;
            flag_ff    <= 1'b0;
            addr_ff    <= 14'h0000;
            wdata_ff   <= 16'h0000;
            byte_en_ff <= 2'h0;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            seen_ff  <= nxt_seen;
            if (take)
            begin
                // Address only moves while strobes are high
                write_ff   <= req_write;
                flag_ff    <= req_flag;
                addr_ff    <= req_addr;
                // Flag request 0, release 1 on bit 0
                wdata_ff   <= req_wdata;
                byte_en_ff <= req_byte_en;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers, registered from the next state
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ce_n_ff  <= 1'b1;
            sem_n_ff <= 1'b1;
            rw_n_ff  <= 1'b1;
            oe_n_ff  <= 1'b1;
            ub_n_ff  <= 1'b1;
            lb_n_ff  <= 1'b1;
            doe_ff   <= 1'b0;
        end
        else if (clk_en)
        begin
            // Exactly one select, held through the strobe
            ce_n_ff  <= !(active && !flag_ff);
            sem_n_ff <= !(active && flag_ff);
            // Write strobe falls with the select so device stays off
            rw_n_ff  <= !(active && write_ff);
            oe_n_ff  <= !(active && !write_ff);
            ub_n_ff  <= !(active && byte_en_ff[1]);
            lb_n_ff  <= !(active && byte_en_ff[0]);
            // Drive data only in write phases
            doe_ff   <= drive;
        end
    end

    // ------------------------------------------------------------
    // Response capture
    // ------------------------------------------------------------
    // Data taken as strobe ends, after any release delay
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_ff     <= 16'h0000;
            rsp_valid_ff <= 1'b0;
            rsp_cont_ff  <= 1'b0;
        end
        else if (clk_en)
        begin
            rsp_valid_ff <= nxt_state[4] && !state_ff[4];
            if (nxt_state[4] && !state_ff[4])
            begin
                rsp_cont_ff <= seen_ff;
                if (!write_ff)
                    rdata_ff <= ram_data_in;
            end
        end
    end

    assign rsp_valid           = rsp_valid_ff;
    assign rsp_rdata           = rdata_ff;
    assign rsp_contended       = rsp_cont_ff;
    assign ram_addr            = addr_ff;
    assign ram_chip_enable_n   = ce_n_ff;
    assign ram_read_write_n    = rw_n_ff;
    assign ram_output_enable_n = oe_n_ff;
    assign flag_select_n       = sem_n_ff;
    assign upper_byte_select_n = ub_n_ff;
    assign lower_byte_select_n = lb_n_ff;
    assign ram_data_out        = wdata_ff;
    assign ram_data_oe         = doe_ff;

endmodule // dpc_port_ctrl

`default_nettype wire
